// ==== hw/pdh_port_handshake.sv ====
// Direction, pin function select, handshake status and warning registers on the multiplexed bus
`timescale 1ns/1ps
module pdh_port_handshake (
	input  wire logic       i_clk,
	input  wire logic       i_reset_n,
	input  wire logic       i_ce,
	input  wire logic       i_as,
	input  wire logic       i_ds,
	input  wire logic       i_rw,
	input  wire logic [7:0] i_ad_in,
	output logic      [7:0] o_ad_out,
	output logic            o_ad_oe,
	input  wire logic [7:0] i_port_a_handshake_control,
	input  wire logic [7:0] i_port_b_handshake_control,
	input  wire logic [3:0] i_hs_edge,
	input  wire logic [3:0] i_hs_irq_mode,
	output logic      [7:0] o_port_a_dir,
	output logic      [7:0] o_port_b_dir,
	output logic      [7:0] o_port_c_dir,
	output logic      [3:0] o_hs_line_sel,
	output logic      [3:0] o_data_access,
	output logic            o_irq_n
);
	logic [3:0] addr_r;
	logic       ds_r;
	logic [7:0] port_a_direction_r;
	logic [7:0] port_b_direction_r;
	logic [7:0] port_c_direction_r;
	logic [7:0] port_c_function_select_r;
	logic [3:0] event_flags_r;
	logic [3:0] warn_flags_r;
	logic [3:0] warn_buf_r;
	logic       access;
	logic       rd;
	logic       wr;
	logic [3:0] data_hit;
	logic [3:0] line_sel;
	logic [3:0] line_in;
	logic [3:0] attempt;
	logic [3:0] irq_en;
	logic       summary_interrupt_flag;
	logic [7:0] rd_data;
	logic [7:0] port_c_dir_nxt;

	// Maps a register address onto the handshake line its data register serves
	function automatic logic [3:0] data_decode(input logic [3:0] a);
		logic [3:0] h;
		h = 4'h0;
		if (a == pdh_pkg::ADDR_DATA_FIRST_A) begin
			h[pdh_pkg::IDX_FIRST_A] = 1'b1;
		end else if (a == pdh_pkg::ADDR_DATA_SECOND_A) begin
			h[pdh_pkg::IDX_SECOND_A] = 1'b1;
		end else if (a == pdh_pkg::ADDR_DATA_FIRST_B) begin
			h[pdh_pkg::IDX_FIRST_B] = 1'b1;
		end else if (a == pdh_pkg::ADDR_DATA_SECOND_B) begin
			h[pdh_pkg::IDX_SECOND_B] = 1'b1;
		end
		return h;
	endfunction

	// Address phase: low nibble of the bus taken while the strobe is high
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			addr_r <= 4'h0;
		end else if (i_as) begin
			addr_r <= i_ad_in[3:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			ds_r <= 1'b0;
		end else begin
			ds_r <= i_ds;
		end
	end

	// One action per data strobe, on its rising edge
	assign access   = i_ce && i_ds && !ds_r;
	assign rd       = access && i_rw;
	assign wr       = access && !i_rw;
	assign data_hit = access ? data_decode(addr_r) : 4'h0;

	// Data accesses go out as pulses whatever the direction bits say
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_data_access <= 4'h0;
		end else begin
			o_data_access <= data_hit;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			port_a_direction_r <= pdh_pkg::DIR_RESET;
			port_b_direction_r <= pdh_pkg::DIR_RESET;
			port_c_direction_r <= pdh_pkg::DIR_RESET;
		end else if (wr) begin
			if (addr_r == pdh_pkg::ADDR_DIR_A) begin
				port_a_direction_r <= i_ad_in;
			end else if (addr_r == pdh_pkg::ADDR_DIR_B) begin
				port_b_direction_r <= i_ad_in;
			end else if (addr_r == pdh_pkg::ADDR_DIR_C) begin
				port_c_direction_r <= i_ad_in;
			end
		end
	end

	// Only the upper nibble is stored so unused bits cannot read back
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			port_c_function_select_r <= pdh_pkg::FUNC_SEL_RESET;
		end else if (wr && addr_r == pdh_pkg::ADDR_FUNC_SEL) begin
			port_c_function_select_r <= {i_ad_in[7:4], 4'h0};
		end
	end

	assign line_sel[pdh_pkg::IDX_FIRST_A]  = port_c_function_select_r[pdh_pkg::SEL_FIRST_A_BIT];
	assign line_sel[pdh_pkg::IDX_FIRST_B]  = port_c_function_select_r[pdh_pkg::SEL_FIRST_B_BIT];
	assign line_sel[pdh_pkg::IDX_SECOND_A] = port_c_function_select_r[pdh_pkg::SEL_SECOND_A_BIT];
	assign line_sel[pdh_pkg::IDX_SECOND_B] = port_c_function_select_r[pdh_pkg::SEL_SECOND_B_BIT];

	// First lines are inputs by nature; second lines only listen while port C calls them inputs
	assign line_in[pdh_pkg::IDX_FIRST_A]  = 1'b1;
	assign line_in[pdh_pkg::IDX_FIRST_B]  = 1'b1;
	assign line_in[pdh_pkg::IDX_SECOND_A] = !port_c_direction_r[pdh_pkg::PIN_SECOND_A];
	assign line_in[pdh_pkg::IDX_SECOND_B] = !port_c_direction_r[pdh_pkg::PIN_SECOND_B];

	assign attempt = i_hs_edge & line_sel & line_in;

	// Selected first handshake pins are forced to input, all else follows port C direction
	always_comb begin
		port_c_dir_nxt = port_c_direction_r;
		if (line_sel[pdh_pkg::IDX_FIRST_A]) begin
			port_c_dir_nxt[pdh_pkg::PIN_FIRST_A] = 1'b0;
		end
		if (line_sel[pdh_pkg::IDX_FIRST_B]) begin
			port_c_dir_nxt[pdh_pkg::PIN_FIRST_B] = 1'b0;
		end
	end

	// Pin controls trail the registers by one cycle to keep outputs on flip-flops
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_port_a_dir  <= pdh_pkg::DIR_RESET;
			o_port_b_dir  <= pdh_pkg::DIR_RESET;
			o_port_c_dir  <= pdh_pkg::DIR_RESET;
			o_hs_line_sel <= 4'h0;
		end else begin
			o_port_a_dir  <= port_a_direction_r;
			o_port_b_dir  <= port_b_direction_r;
			o_port_c_dir  <= port_c_dir_nxt;
			o_hs_line_sel <= line_sel;
		end
	end

	// Set beats clear so an edge landing on the servicing access is kept
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			event_flags_r <= pdh_pkg::FLAGS_RESET;
		end else begin
			event_flags_r <= (event_flags_r & ~data_hit) | attempt;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			warn_flags_r <= pdh_pkg::FLAGS_RESET;
		end else if (rd && addr_r == pdh_pkg::ADDR_WARNING) begin
			warn_flags_r <= (warn_flags_r & ~warn_buf_r) | (attempt & event_flags_r);
		end else begin
			warn_flags_r <= warn_flags_r | (attempt & event_flags_r);
		end
	end

	// Buffer arms a clear only for a warning that was standing at the data read
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			warn_buf_r <= 4'h0;
		end else if (rd && addr_r == pdh_pkg::ADDR_WARNING) begin
			warn_buf_r <= 4'h0;
		end else if (rd && data_hit != 4'h0) begin
			warn_buf_r <= data_hit & warn_flags_r;
		end
	end

	assign irq_en[pdh_pkg::IDX_FIRST_A]  = i_port_a_handshake_control[pdh_pkg::CTRL_IRQ_EN_FIRST];
	assign irq_en[pdh_pkg::IDX_FIRST_B]  = i_port_b_handshake_control[pdh_pkg::CTRL_IRQ_EN_FIRST];
	assign irq_en[pdh_pkg::IDX_SECOND_A] = i_port_a_handshake_control[pdh_pkg::CTRL_IRQ_EN_SECOND];
	assign irq_en[pdh_pkg::IDX_SECOND_B] = i_port_b_handshake_control[pdh_pkg::CTRL_IRQ_EN_SECOND];

	assign summary_interrupt_flag = |(event_flags_r & irq_en & i_hs_irq_mode);

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_irq_n <= 1'b1;
		end else begin
			o_irq_n <= !summary_interrupt_flag;
		end
	end

	// Own registers only; neighbours answer the rest of the map
	function automatic logic is_own(input logic [3:0] a);
		return a == pdh_pkg::ADDR_DIR_A || a == pdh_pkg::ADDR_DIR_B || a == pdh_pkg::ADDR_DIR_C ||
			a == pdh_pkg::ADDR_FUNC_SEL || a == pdh_pkg::ADDR_EVENT_STATUS || a == pdh_pkg::ADDR_WARNING;
	endfunction

	// Read mux; data and control registers belong to neighbours, so no drive there
	always_comb begin
		rd_data = 8'h00;
		if (addr_r == pdh_pkg::ADDR_DIR_A) begin
			rd_data = port_a_direction_r;
		end else if (addr_r == pdh_pkg::ADDR_DIR_B) begin
			rd_data = port_b_direction_r;
		end else if (addr_r == pdh_pkg::ADDR_DIR_C) begin
			rd_data = port_c_direction_r;
		end else if (addr_r == pdh_pkg::ADDR_FUNC_SEL) begin
			rd_data = port_c_function_select_r;
		end else if (addr_r == pdh_pkg::ADDR_EVENT_STATUS) begin
			rd_data = {summary_interrupt_flag, 3'h0, event_flags_r};
		end else if (addr_r == pdh_pkg::ADDR_WARNING) begin
			rd_data = {4'h0, warn_flags_r};
		end
	end

	// Status and warning ignore writes: no write path exists for them
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_ad_out <= 8'h00;
			o_ad_oe  <= 1'b0;
		end else begin
			if (rd) begin
				o_ad_out <= rd_data;
			end
			o_ad_oe <= i_ce && i_ds && i_rw && (ds_r ? o_ad_oe : (rd_data != 8'h00 || is_own(addr_r)));
		end
	end
endmodule

// ==== include/pdh_pkg.sv ====
// Register map, field positions and reset values of the port direction and handshake status block
package pdh_pkg;
	localparam logic [3:0] ADDR_DATA_FIRST_A   = 4'h0;
	localparam logic [3:0] ADDR_DATA_SECOND_A  = 4'h1;
	localparam logic [3:0] ADDR_DIR_A          = 4'h6;
	localparam logic [3:0] ADDR_DIR_B          = 4'h7;
	localparam logic [3:0] ADDR_DIR_C          = 4'h8;
	localparam logic [3:0] ADDR_FUNC_SEL       = 4'hb;
	localparam logic [3:0] ADDR_DATA_FIRST_B   = 4'hc;
	localparam logic [3:0] ADDR_DATA_SECOND_B  = 4'hd;
	localparam logic [3:0] ADDR_EVENT_STATUS   = 4'he;
	localparam logic [3:0] ADDR_WARNING        = 4'hf;

	// Event, warning and line index order
	localparam int IDX_FIRST_A  = 0;
	localparam int IDX_FIRST_B  = 1;
	localparam int IDX_SECOND_A = 2;
	localparam int IDX_SECOND_B = 3;

	// Function select field positions
	localparam int SEL_FIRST_A_BIT  = 4;
	localparam int SEL_SECOND_A_BIT = 5;
	localparam int SEL_FIRST_B_BIT  = 6;
	localparam int SEL_SECOND_B_BIT = 7;

	// Port C pins carrying handshake lines
	localparam int PIN_FIRST_A  = 4;
	localparam int PIN_SECOND_A = 5;
	localparam int PIN_FIRST_B  = 6;
	localparam int PIN_SECOND_B = 7;

	// Interrupt enables inside each port's control register
	localparam int CTRL_IRQ_EN_FIRST  = 0;
	localparam int CTRL_IRQ_EN_SECOND = 3;

	localparam int SUMMARY_IRQ_BIT = 7;

	localparam logic [7:0] DIR_RESET      = 8'h00;
	localparam logic [7:0] FUNC_SEL_RESET = 8'h00;
	localparam logic [3:0] FLAGS_RESET    = 4'h0;
endpackage

// ==== testbench/pdh_port_handshake_monitor.sv ====
// Checker on the top ports of the direction and handshake status block
`timescale 1ns/1ps
module pdh_port_handshake_monitor (
	input wire logic       i_clk,
	input wire logic       i_reset_n,
	input wire logic       i_ce,
	input wire logic       i_as,
	input wire logic       i_ds,
	input wire logic       i_rw,
	input wire logic [7:0] i_ad_in,
	input wire logic [7:0] o_ad_out,
	input wire logic       o_ad_oe,
	input wire logic [7:0] i_port_a_handshake_control,
	input wire logic [7:0] i_port_b_handshake_control,
	input wire logic [3:0] i_hs_edge,
	input wire logic [3:0] i_hs_irq_mode,
	input wire logic [7:0] o_port_a_dir,
	input wire logic [7:0] o_port_b_dir,
	input wire logic [7:0] o_port_c_dir,
	input wire logic [3:0] o_hs_line_sel,
	input wire logic [3:0] o_data_access,
	input wire logic       o_irq_n
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	sequence s_no_enable;
		!i_port_a_handshake_control[0] && !i_port_a_handshake_control[3] &&
		!i_port_b_handshake_control[0] && !i_port_b_handshake_control[3];
	endsequence
	a_reset_dir_zero: assert property (disable iff (1'b0)
		!i_reset_n |=> (o_port_a_dir | o_port_b_dir | o_port_c_dir) == 8'h00) else $error("dir not cleared");
	a_reset_sel_zero: assert property (disable iff (1'b0)
		!i_reset_n |=> o_hs_line_sel == 4'h0 && o_irq_n) else $error("select or irq not cleared");
	a_oe_after_read: assert property (
		o_ad_oe |-> $past(i_ds && i_ce && i_rw)) else $error("bus driven without read");
	a_oe_drops_fast: assert property (
		!i_ds |=> !o_ad_oe) else $error("bus held after strobe");
	a_first_a_input: assert property (
		o_hs_line_sel[0] && $past(o_hs_line_sel[0]) |-> !o_port_c_dir[4]) else $error("pin 4 driven");
	a_first_b_input: assert property (
		o_hs_line_sel[1] && $past(o_hs_line_sel[1]) |-> !o_port_c_dir[6]) else $error("pin 6 driven");
	a_access_pulse_one: assert property (
		o_data_access != 4'h0 |=> o_data_access == 4'h0) else $error("access pulse too long");
	a_irq_masked_off: assert property (
		s_no_enable [*3] |-> o_irq_n) else $error("irq with no enable");
endmodule

// ==== testbench/pdh_mpu_model.sv ====
// Multiplexed bus master model standing in for the microprocessor
`timescale 1ns/1ps
module pdh_mpu_model (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_ad_out,
	input  wire logic       i_ad_oe,
	output logic            o_ce,
	output logic            o_as,
	output logic            o_ds,
	output logic            o_rw,
	output logic      [7:0] o_ad
);
	initial begin
		o_ce = 1'b0;
		o_as = 1'b0;
		o_ds = 1'b0;
		o_rw = 1'b1;
		o_ad = 8'h00;
	end
	// Moves on falling edges; strobe held across the taking edge
	task automatic access(input logic [3:0] a, input logic rw, input logic [7:0] d,
		output logic [7:0] rdata, output logic oe);
		@(negedge i_clk);
		o_ce = 1'b1;
		o_as = 1'b1;
		o_ad = {4'h0, a};
		@(negedge i_clk);
		o_as = 1'b0;
		o_ds = 1'b1;
		o_rw = rw;
		o_ad = rw ? ~o_ad : d; // Released bus never shows a stale address
		repeat (2) @(posedge i_clk);
		#1;
		rdata = i_ad_out;
		oe = i_ad_oe;
		@(negedge i_clk);
		o_ds = 1'b0;
		o_ce = 1'b0;
		o_ad = ~o_ad;
	endtask
endmodule

// ==== testbench/tb_pdh_port_handshake.sv ====
// Self-checking bench for the direction and handshake status block
`timescale 1ns/1ps
module tb_pdh_port_handshake;
	logic       i_clk, i_reset_n, i_ce, i_as, i_ds, i_rw, o_ad_oe, o_irq_n, oe;
	logic [7:0] i_ad_in, o_ad_out, i_port_a_handshake_control, i_port_b_handshake_control, rd;
	logic [7:0] o_port_a_dir, o_port_b_dir, o_port_c_dir;
	logic [3:0] i_hs_edge, i_hs_irq_mode, o_hs_line_sel, o_data_access;
	logic [3:0] regs [6] = '{4'h6, 4'h7, 4'h8, 4'hb, 4'he, 4'hf};
	int         errors = 0, cmp_count = 0, cyc = 0, acc_pulses = 0;
	logic [7:0] acc_lines = 8'h00;
	// Every data register access must show up as exactly one pulse
	always @(posedge i_clk) begin
		if (o_data_access != 4'h0) begin
			acc_pulses++;
			acc_lines = acc_lines | {4'h0, o_data_access};
		end
	end
	pdh_port_handshake u_pdh_port_handshake (.*);
	pdh_mpu_model u_pdh_mpu_model (.i_clk(i_clk), .i_ad_out(o_ad_out), .i_ad_oe(o_ad_oe), .o_ce(i_ce),
		.o_as(i_as), .o_ds(i_ds), .o_rw(i_rw), .o_ad(i_ad_in));
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic acc(input logic [3:0] a, input logic rwv, input logic [7:0] d);
		u_pdh_mpu_model.access(a, rwv, d, rd, oe);
	endtask
	task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
		acc(a, 1'b1, 8'h00);
		chk(rd, exp, "read data");
		chk({7'h00, oe}, 8'h01, "bus enable");
	endtask
	task automatic pulse(input logic [3:0] v);
		@(negedge i_clk);
		i_hs_edge = v;
		@(negedge i_clk);
		i_hs_edge = 4'h0;
		repeat (2) @(negedge i_clk);
	endtask
	task automatic close_out;
		$display("Compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Hang guard far above the roughly 150 cycles the sequence needs
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			close_out();
		end
	end
	initial begin
		i_reset_n = 1'b0;
		i_hs_edge = 4'h0;
		i_hs_irq_mode = 4'hf;
		i_port_a_handshake_control = 8'h09;
		i_port_b_handshake_control = 8'h09;
		repeat (8) @(negedge i_clk);
		i_reset_n = 1'b1;
		foreach (regs[k]) begin
			rdchk(regs[k], 8'h00);
		end
		acc(4'h6, 1'b0, 8'h5a);
		acc(4'h7, 1'b0, 8'ha5);
		acc(4'h8, 1'b0, 8'h5f);
		rdchk(4'h6, 8'h5a);
		rdchk(4'h7, 8'ha5);
		rdchk(4'h8, 8'h5f);
		chk(o_port_a_dir ^ o_port_b_dir, 8'hff, "port a b dir");
		chk(o_port_c_dir, 8'h5f, "port c dir");
		pulse(4'hf);
		rdchk(4'he, 8'h00);
		acc(4'hb, 1'b0, 8'hff);
		rdchk(4'hb, 8'hf0);
		chk({4'h0, o_hs_line_sel}, 8'h0f, "line select");
		chk(o_port_c_dir, 8'h0f, "port c dir");
		acc(4'he, 1'b0, 8'hff);
		rdchk(4'he, 8'h00);
		pulse(4'hf);
		rdchk(4'he, 8'h8f);
		chk({7'h00, o_irq_n}, 8'h00, "irq");
		pulse(4'h3);
		rdchk(4'hf, 8'h03);
		rdchk(4'hf, 8'h03);
		acc(4'h0, 1'b1, 8'h00);
		rdchk(4'he, 8'h8e);
		acc(4'hf, 1'b1, 8'h00);
		rdchk(4'hf, 8'h02);
		i_port_a_handshake_control = 8'h00;
		i_port_b_handshake_control = 8'h00;
		rdchk(4'he, 8'h0e);
		chk({7'h00, o_irq_n}, 8'h01, "irq");
		acc(4'h1, 1'b0, 8'h00);
		acc(4'hc, 1'b0, 8'h00);
		acc(4'hd, 1'b0, 8'h00);
		rdchk(4'he, 8'h00);
		i_port_a_handshake_control = 8'h09;
		i_hs_irq_mode = 4'h0;
		pulse(4'h1);
		chk({7'h00, o_irq_n}, 8'h01, "irq mode");
		acc(4'h5, 1'b1, 8'h00);
		chk({7'h00, oe}, 8'h00, "unmapped enable");
		chk(acc_pulses[7:0], 8'h04, "data access pulses");
		chk(acc_lines, 8'h0f, "data access lines");
		close_out();
	end
endmodule
bind pdh_port_handshake pdh_port_handshake_monitor u_pdh_port_handshake_monitor (.*);
